// *** hdl/rtc_seconds_minutes_trim.sv ***
// Seconds and minutes counters with busy flag and half-ppm rate trim.
// Operation
// - Rate shifts by (trim code minus 60)/2 ppm.
// - Trim span is -30 to +33.5 ppm.
// - Busy in seconds bit 7; host waits.
// - Seconds count bits 5:0, 0 to 59.
// - Minutes count bits 5:0, 0 to 59.
// - Reset clears whole seconds register, busy included.
module rtc_seconds_minutes_trim #(
	parameter int TICKS_PER_SEC = rtc_pkg::NOM_TICKS
) (
	input wire logic core_clk,
	input wire logic reset,
	input rtc_pkg::reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic timebase_pin,
	output logic minute_carry,
	output logic busy
);
	// Synchroniser for the low-frequency timebase pin, plus one stage for edge detection.
	logic tb_meta_reg, tb_sync_reg, tb_prev_reg;
	logic tb_meta_next, tb_sync_next, tb_prev_next;
	// Rising edge of the synchronised timebase; one per tick.
	logic tick;
	// Ticks counted in the current second, and the length of this second in ticks.
	logic [16:0] tick_cnt_reg, tick_cnt_next;
	logic [16:0] len_reg, len_next;
	// Signed trim error, carried from second to second.
	logic signed [24:0] acc_reg, acc_next;
	// Busy window counter; the counters advance as it runs out.
	logic [7:0] busy_cnt_reg, busy_cnt_next;
	// Register contents.
	logic [rtc_pkg::TRIM_W-1:0] trim_reg, trim_next;
	logic [rtc_pkg::TIME_W-1:0] sec_reg, sec_next;
	logic [rtc_pkg::TIME_W-1:0] min_reg, min_next;
	// Read data and carry pulse, both registered.
	logic [7:0] rdata_reg, rdata_next;
	logic carry_reg, carry_next;
	// Length of the busy window as a local constant, so that property delays stay plain.
	localparam int BUSY_LEN = rtc_pkg::BUSY_CYCLES;
	// Helpers for the second boundary and the trim arithmetic.
	logic sec_end, advance;
	logic signed [7:0] delta;
	logic signed [24:0] step, acc_sum;

	// Timebase synchroniser; only the second and third stages are looked at.
	always_comb begin
		tb_meta_next = timebase_pin;
		tb_sync_next = tb_meta_reg;
		tb_prev_next = tb_sync_reg;
		tick = tb_sync_reg & ~tb_prev_reg;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tb_meta_reg <= 1'b0;
			tb_sync_reg <= 1'b0;
			tb_prev_reg <= 1'b0;
		end else begin
			tb_meta_reg <= tb_meta_next;
			tb_sync_reg <= tb_sync_next;
			tb_prev_reg <= tb_prev_next;
		end
	end

	// Second pacing with trim: each second's length is nominal, or one tick shorter or
	// longer when the accumulated error reaches a whole tick.
	always_comb begin
		sec_end = tick && (tick_cnt_reg == len_reg - 17'd1);
		// Offset code minus the centre gives the correction in half-ppm steps.
		delta = signed'({1'b0, trim_reg}) - signed'(rtc_pkg::TRIM_CENTER);
		step = 25'(delta) <<< rtc_pkg::STEP_SHIFT;
		acc_sum = acc_reg + step;
		tick_cnt_next = tick_cnt_reg;
		len_next = len_reg;
		acc_next = acc_reg;
		if (sec_end) begin
			tick_cnt_next = '0;
			// A fast trim drops one tick, a slow trim adds one; the remainder carries.
			if (acc_sum >= rtc_pkg::TICK_UNITS) begin
				len_next = 17'(TICKS_PER_SEC - 1);
				acc_next = acc_sum - rtc_pkg::TICK_UNITS;
			end else if (acc_sum <= -rtc_pkg::TICK_UNITS) begin
				len_next = 17'(TICKS_PER_SEC + 1);
				acc_next = acc_sum + rtc_pkg::TICK_UNITS;
			end else begin
				len_next = 17'(TICKS_PER_SEC);
				acc_next = acc_sum;
			end
		end else if (tick) begin
			tick_cnt_next = tick_cnt_reg + 17'd1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tick_cnt_reg <= '0;
			len_reg <= 17'(TICKS_PER_SEC);
			acc_reg <= '0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			len_reg <= len_next;
			acc_reg <= acc_next;
		end
	end

	// Busy window: opens at the second boundary, and the counts move on its last cycle.
	always_comb begin
		busy_cnt_next = busy_cnt_reg;
		if (sec_end) begin
			busy_cnt_next = 8'(rtc_pkg::BUSY_CYCLES);
		end else if (busy_cnt_reg != 8'h00) begin
			busy_cnt_next = busy_cnt_reg - 8'h01;
		end
		advance = (busy_cnt_reg == 8'h01);
		busy = (busy_cnt_reg != 8'h00);
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			busy_cnt_reg <= '0;
		end else begin
			busy_cnt_reg <= busy_cnt_next;
		end
	end

	// Counters and register writes. Time writes are dropped while busy; the trim may
	// change at any time and takes effect at the next second boundary.
	always_comb begin
		trim_next = trim_reg;
		sec_next = sec_reg;
		min_next = min_reg;
		carry_next = 1'b0;
		if (advance) begin
			// Seconds wrap at 59 and carry into minutes, minutes carry out to hours.
			if (sec_reg >= rtc_pkg::TIME_MAX) begin
				sec_next = rtc_pkg::TIME_ZERO;
				if (min_reg >= rtc_pkg::TIME_MAX) begin
					min_next = rtc_pkg::TIME_ZERO;
					carry_next = 1'b1;
				end else begin
					min_next = min_reg + 6'h01;
				end
			end else begin
				sec_next = sec_reg + 6'h01;
			end
		end else if (reg_req.write && !busy) begin
			if (reg_req.addr == rtc_pkg::ADDR_SEC) begin
				sec_next = reg_req.wdata[rtc_pkg::TIME_W-1:0];
			end else if (reg_req.addr == rtc_pkg::ADDR_MIN) begin
				min_next = reg_req.wdata[rtc_pkg::TIME_W-1:0];
			end
		end
		if (reg_req.write && reg_req.addr == rtc_pkg::ADDR_TRIM) begin
			trim_next = reg_req.wdata[rtc_pkg::TRIM_W-1:0];
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			trim_reg <= rtc_pkg::TRIM_CENTER[rtc_pkg::TRIM_W-1:0];
			sec_reg <= rtc_pkg::TIME_ZERO;
			min_reg <= rtc_pkg::TIME_ZERO;
			carry_reg <= 1'b0;
		end else begin
			trim_reg <= trim_next;
			sec_reg <= sec_next;
			min_reg <= min_next;
			carry_reg <= carry_next;
		end
	end

	// Read path: data is registered one cycle after the read; unmapped reads give zero.
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_req.read) begin
			case (reg_req.addr)
				rtc_pkg::ADDR_TRIM: rdata_next = {1'b0, trim_reg};
				// Busy flag above a reserved zero bit and the seconds count.
				rtc_pkg::ADDR_SEC: rdata_next = {busy, 1'b0, sec_reg};
				rtc_pkg::ADDR_MIN: rdata_next = {2'b00, min_reg};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign minute_carry = carry_reg;

	// Boundary followed by the closing of the busy window.
	sequence s_boundary;
		sec_end ##(BUSY_LEN) advance;
	endsequence

	a_trim_fast_tick: assert property (@(posedge core_clk) disable iff (reset)
		sec_end && acc_sum >= rtc_pkg::TICK_UNITS |=> len_reg == 17'(TICKS_PER_SEC - 1))
		else $error("fast trim did not shorten the second");
	a_trim_slow_tick: assert property (@(posedge core_clk) disable iff (reset)
		sec_end && acc_sum <= -rtc_pkg::TICK_UNITS |=> len_reg == 17'(TICKS_PER_SEC + 1))
		else $error("slow trim did not lengthen the second");
	a_busy_window: assert property (@(posedge core_clk) disable iff (reset)
		s_boundary |-> busy ##1 !busy || sec_end)
		else $error("busy window has the wrong length");
	a_busy_blocks_write: assert property (@(posedge core_clk) disable iff (reset)
		busy && !advance |=> sec_reg == $past(sec_reg) && min_reg == $past(min_reg))
		else $error("time register changed while busy");
	a_sec_wrap: assert property (@(posedge core_clk) disable iff (reset)
		advance && sec_reg == rtc_pkg::TIME_MAX |=> sec_reg == rtc_pkg::TIME_ZERO)
		else $error("seconds did not wrap at 59");
	a_min_wrap: assert property (@(posedge core_clk) disable iff (reset)
		advance && sec_reg == rtc_pkg::TIME_MAX && min_reg == rtc_pkg::TIME_MAX
		|=> min_reg == rtc_pkg::TIME_ZERO && minute_carry)
		else $error("minutes did not wrap with a carry");
	a_reset_clears: assert property (@(posedge core_clk)
		reset |=> sec_reg == rtc_pkg::TIME_ZERO && !busy)
		else $error("seconds register not cleared by reset");
	a_sec_advance: assert property (@(posedge core_clk) disable iff (reset)
		advance && sec_reg < rtc_pkg::TIME_MAX |=> sec_reg == $past(sec_reg) + 6'h01)
		else $error("seconds did not advance once");
endmodule

// *** hdl/rtc_pkg.sv ***
// Shared constants and types for the seconds, minutes and trim slice of the real-time clock.
package rtc_pkg;
	// Byte addresses of the three registers on the serial control port.
	localparam logic [7:0] ADDR_TRIM = 8'h11;
	localparam logic [7:0] ADDR_SEC = 8'h12;
	localparam logic [7:0] ADDR_MIN = 8'h13;
	// Position of the busy flag inside the seconds register.
	localparam int SEC_BUSY_BIT = 7;
	// Width of the trim code field, bits 6 to 0.
	localparam int TRIM_W = 7;
	// Width of the seconds and minutes fields, bits 5 to 0.
	localparam int TIME_W = 6;
	// Highest value of a seconds or minutes count before it wraps.
	localparam logic [5:0] TIME_MAX = 6'h3b;
	// Zero value of the seconds and minutes counts.
	localparam logic [5:0] TIME_ZERO = 6'h00;
	// Trim code that gives no correction, and the reset value of the trim register.
	localparam logic [7:0] TRIM_CENTER = 8'h3c;
	// Nominal timebase ticks in one second.
	localparam int NOM_TICKS = 32768;
	// One timebase tick, expressed in half-ppm units scaled by the nominal tick count.
	localparam logic signed [24:0] TICK_UNITS = 25'sd2000000;
	// Left shift that multiplies a half-ppm step by the nominal tick count.
	localparam int STEP_SHIFT = 15;
	// Time that the busy flag stands while the counters update.
	localparam int BUSY_TIME_NS = 100;
	// Period of core_clk.
	localparam int CLK_PERIOD_NS = 10;
	// Busy window in core_clk cycles, rounded up.
	localparam int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// One register access request from the serial control port decoder.
	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;
endpackage

// *** bench/tb_rtc_seconds_minutes_trim.sv ***
// Self-checking testbench for the seconds, minutes and trim slice of the real-time clock.
module tb_rtc_seconds_minutes_trim;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk; // Core clock, 100 MHz.
	logic reset; // Synchronous reset, active high.
	logic timebase_pin; // Low-frequency timebase driven by the bench.
	rtc_pkg::reg_req_t reg_req; // Register request towards the block.
	logic [7:0] reg_rdata;
	logic minute_carry;
	logic busy;
	int mismatches; // Count of failed comparisons.
	int checks; // Count of all comparisons.
	int busy_len; // Cycles that busy stood high.
	int carries; // Minute carry pulses seen.
	int n;

	// A short second keeps the run brief; eight ticks make one second.
	rtc_seconds_minutes_trim #(.TICKS_PER_SEC(8)) rtc_seconds_minutes_trim_i (
		.core_clk(core_clk),
		.reset(reset),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.timebase_pin(timebase_pin),
		.minute_carry(minute_carry),
		.busy(busy)
	);

	// Free-running clock.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Counts busy cycles and carry pulses at each falling edge, where both have settled.
	always @(negedge core_clk) begin
		if (busy === 1'b1) busy_len++;
		if (minute_carry === 1'b1) carries++;
	end

	// Compares one value and reports a difference.
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// One-cycle write strobe; the strobe drops one cycle later.
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk);
		#1 reg_req = '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
		@(posedge core_clk);
		#1 reg_req.write = 1'b0;
	endtask

	// One-cycle read strobe; data is registered on the taking edge.
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input string what);
		@(posedge core_clk);
		#1 reg_req = '{write: 1'b0, read: 1'b1, addr: addr, wdata: 8'h00};
		@(posedge core_clk);
		#1 reg_req.read = 1'b0;
		check(what, reg_rdata, exp);
	endtask

	// Timebase ticks spaced fifteen core cycles apart.
	task automatic ticks(input int cnt);
		repeat (cnt) begin
			@(posedge core_clk);
			#1 timebase_pin = 1'b1;
			repeat (7) @(posedge core_clk);
			#1 timebase_pin = 1'b0;
			repeat (7) @(posedge core_clk);
		end
	endtask

	// Hang guard sized well above the expected run.
	initial begin
		#200us;
		mismatches++;
		conclude();
	end

	// Main sequence.
	initial begin
		reset = 1'b1;
		timebase_pin = 1'b0;
		reg_req = '{write: 1'b0, read: 1'b0, addr: 8'h00, wdata: 8'h00};
		repeat (20) @(posedge core_clk);
		#1 reset = 1'b0;
		rd(rtc_pkg::ADDR_TRIM, rtc_pkg::TRIM_CENTER, "trim reset");
		rd(rtc_pkg::ADDR_SEC, 8'h00, "seconds reset");
		rd(rtc_pkg::ADDR_MIN, 8'h00, "minutes reset");
		rd(8'h20, 8'h00, "unmapped read");
		wr(rtc_pkg::ADDR_TRIM, 8'hff);
		rd(rtc_pkg::ADDR_TRIM, 8'h7f, "trim top code");
		wr(rtc_pkg::ADDR_TRIM, rtc_pkg::TRIM_CENTER);
		wr(rtc_pkg::ADDR_MIN, 8'hff);
		rd(rtc_pkg::ADDR_MIN, 8'h3f, "minutes field");
		wr(rtc_pkg::ADDR_SEC, 8'h3b);
		wr(rtc_pkg::ADDR_MIN, 8'h3b);
		rd(rtc_pkg::ADDR_SEC, 8'h3b, "seconds field");
		// Seven ticks, then the eighth is held up while the update runs.
		busy_len = 0;
		carries = 0;
		ticks(7);
		@(posedge core_clk);
		#1 timebase_pin = 1'b1;
		n = 0;
		while (busy !== 1'b1 && n < 50) begin
			@(posedge core_clk);
			#1 n++;
		end
		rd(rtc_pkg::ADDR_SEC, 8'hbb, "busy flag");
		// Writes during the update must be dropped.
		wr(rtc_pkg::ADDR_SEC, 8'h05);
		wr(rtc_pkg::ADDR_MIN, 8'h05);
		repeat (20) @(posedge core_clk);
		#1 timebase_pin = 1'b0;
		rd(rtc_pkg::ADDR_SEC, 8'h00, "seconds wrap");
		rd(rtc_pkg::ADDR_MIN, 8'h00, "minutes wrap");
		check("busy length", 8'(busy_len), 8'(rtc_pkg::BUSY_CYCLES));
		check("minute carry", 8'(carries), 8'h01);
		// One more full second advances seconds only.
		ticks(8);
		repeat (20) @(posedge core_clk);
		rd(rtc_pkg::ADDR_SEC, 8'h01, "seconds step");
		rd(rtc_pkg::ADDR_MIN, 8'h00, "minutes hold");
		check("carry count", 8'(carries), 8'h01);
		// Top trim code: the boundary after it makes the following second one tick short.
		wr(rtc_pkg::ADDR_TRIM, 8'h7f);
		ticks(8);
		rd(rtc_pkg::ADDR_SEC, 8'h02, "trim nominal second");
		ticks(7);
		rd(rtc_pkg::ADDR_SEC, 8'h03, "trim fast second");
		// Bottom trim code: the error builds up until one second is a tick long.
		wr(rtc_pkg::ADDR_TRIM, 8'h00);
		ticks(7);
		rd(rtc_pkg::ADDR_SEC, 8'h04, "trim last fast second");
		ticks(8);
		rd(rtc_pkg::ADDR_SEC, 8'h05, "trim slow build");
		ticks(8);
		rd(rtc_pkg::ADDR_SEC, 8'h05, "trim slow second");
		ticks(1);
		rd(rtc_pkg::ADDR_SEC, 8'h06, "trim slow end");
		// A second reset in mid-run clears the seconds register again.
		@(posedge core_clk);
		#1 reset = 1'b1;
		repeat (3) @(posedge core_clk);
		#1 reset = 1'b0;
		rd(rtc_pkg::ADDR_SEC, 8'h00, "seconds rereset");
		rd(rtc_pkg::ADDR_TRIM, rtc_pkg::TRIM_CENTER, "trim rereset");
		conclude();
	end
endmodule
